// ==== include/drsc_pkg.sv ====
// Package for the dual-mode receive sampler control block
package drsc_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ          = 100_000_000;
    localparam int unsigned DIG_RATE_SPS_X10 = 486_000;
    localparam int unsigned ANA_RATE_HZ     = 40_000;
    localparam int unsigned DIG_TICK_CYC    = (CLK_HZ * 10) / DIG_RATE_SPS_X10;
    localparam int unsigned ANA_TICK_CYC    = CLK_HZ / ANA_RATE_HZ;
    localparam int unsigned TICK_W          = 12;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_I_SAMPLE = 8'h04;
    localparam logic [7:0] OFS_Q_SAMPLE = 8'h08;
    localparam logic [7:0] OFS_STATUS   = 8'h0C;
    localparam logic [7:0] OFS_IRQ_EN   = 8'h10;
    localparam logic [7:0] OFS_IRQ_CLR  = 8'h14;
    localparam logic [7:0] OFS_PATH     = 8'h18;

    localparam int unsigned ADDR_W   = 8;
    localparam int unsigned SAMPLE_W = 10;

    // Control field positions
    localparam int unsigned BIT_MODE  = 0;
    localparam int unsigned BIT_VOICE = 1;
    localparam int unsigned BIT_IQEN  = 2;
    localparam int unsigned BIT_FMEN  = 3;
    localparam int unsigned CTRL_W    = 4;

    // Status bits: 0 sample ready, 1 sample overwritten before read
    localparam int unsigned ST_READY   = 0;
    localparam int unsigned ST_OVERRUN = 1;
    localparam int unsigned ST_W       = 2;

    localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef struct packed {
        logic fm_receive_enable;
        logic iq_receive_enable;
        logic voice_path_select;
        logic mode_digital;
    } drsc_ctrl_t;

    typedef struct packed {
        logic i_chan_en;
        logic q_chan_en;
        logic fm_to_q_mux;
        logic q_neg_to_bias;
        logic ext_rx_en;
        logic bias_ref_en;
    } drsc_path_t;

    typedef struct packed {
        logic [SAMPLE_W-1:0] i;
        logic [SAMPLE_W-1:0] q;
    } drsc_pair_t;

endpackage : drsc_pkg

// ==== rtl/drsc_receive_ctrl.sv ====
// Receive path control: mode decode, sample pacing, sample registers, AXI4-Lite
//
// Functional notes
// - Sample words are two's complement, sign-extended onto the bus.
// - Digital mode stores each I and Q result in its 10-bit register.
// - Digital mode sample rate is 48.6 ksps.
// - Analog mode: voice select bit enables the Q conversion channel.
// - Analog mode: FM receive enable drives external receive functions.
// - Digital mode: I/Q enable turns on I, Q and external functions.
// - Voice select set routes FM to Q positive, Q negative to bias.
// - Both channels enabled digitally only with mode and I/Q enable high.
// - I and Q channels share one enable in digital mode; I is never on without Q.
// - Analog mode keeps I disabled; samples come from Q only.
// - Sample-ready interrupt raised once registers hold new samples.
// - Analog mode sample rate is 40 kHz.
`timescale 1ns/100ps
module drsc_receive_ctrl (
    input  wire logic                          aclk,
    input  wire logic                          aresetn,
    input  wire logic [drsc_pkg::ADDR_W-1:0]   s_axi_awaddr,
    input  wire logic                          s_axi_awvalid,
    output logic                               s_axi_awready,
    input  wire logic [31:0]                   s_axi_wdata,
    input  wire logic [3:0]                    s_axi_wstrb,
    input  wire logic                          s_axi_wvalid,
    output logic                               s_axi_wready,
    output logic [1:0]                         s_axi_bresp,
    output logic                               s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    input  wire logic [drsc_pkg::ADDR_W-1:0]   s_axi_araddr,
    input  wire logic                          s_axi_arvalid,
    output logic                               s_axi_arready,
    output logic [31:0]                        s_axi_rdata,
    output logic [1:0]                         s_axi_rresp,
    output logic                               s_axi_rvalid,
    input  wire logic                          s_axi_rready,
    input  wire logic [drsc_pkg::SAMPLE_W-1:0] adc_i_result,
    input  wire logic [drsc_pkg::SAMPLE_W-1:0] adc_q_result,
    output drsc_pkg::drsc_path_t               path_ctrl,
    output logic                               sample_ready_irq
);
    import drsc_pkg::*;

    // --------------------------------------------------------
    // State
    // --------------------------------------------------------
    drsc_ctrl_t          ctrl_reg,    ctrl_next;
    drsc_pair_t          sample_reg,  sample_next;
    drsc_path_t          path_reg,    path_next;
    logic [ST_W-1:0]     status_reg,  status_next;
    logic [ST_W-1:0]     irq_en_reg,  irq_en_next;
    logic                unread_reg,  unread_next;
    logic                irq_reg,     irq_next;
    logic                aw_got_reg,  aw_got_next;
    logic                w_got_reg,   w_got_next;
    logic [ADDR_W-1:0]   awaddr_reg,  awaddr_next;
    logic [31:0]         wdata_reg,   wdata_next;
    logic [3:0]          wstrb_reg,   wstrb_next;
    logic                bvalid_reg,  bvalid_next;
    logic [1:0]          bresp_reg,   bresp_next;
    logic                rvalid_reg,  rvalid_next;
    logic [1:0]          rresp_reg,   rresp_next;
    logic [31:0]         rdata_reg,   rdata_next;

    logic [SAMPLE_W-1:0] adc_i_s1, adc_i_s2;
    logic [SAMPLE_W-1:0] adc_q_s1, adc_q_s2;
    logic                tick;
    logic                run;
    logic                aw_hs, w_hs, ar_hs, do_write;
    logic                rd_q_sample;
    logic [ST_W-1:0]     clr_bits;
    logic [ST_W-1:0]     set_bits;

    // --------------------------------------------------------
    // Converter results cross in from the analog side
    // --------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            adc_i_s1 <= '0;
            adc_i_s2 <= '0;
            adc_q_s1 <= '0;
            adc_q_s2 <= '0;
        end else begin
            adc_i_s1 <= adc_i_result;
            adc_i_s2 <= adc_i_s1;
            adc_q_s1 <= adc_q_result;
            adc_q_s2 <= adc_q_s1;
        end
    end

    // --------------------------------------------------------
    // Path decode
    // --------------------------------------------------------
    always_comb begin
        path_next = '0;
        if (ctrl_reg.mode_digital) begin
            path_next.i_chan_en = ctrl_reg.iq_receive_enable;
            path_next.q_chan_en = ctrl_reg.iq_receive_enable;
            path_next.ext_rx_en = ctrl_reg.iq_receive_enable;
        end else begin
            path_next.i_chan_en = 1'b0;
            path_next.q_chan_en = ctrl_reg.voice_path_select;
            path_next.ext_rx_en = ctrl_reg.fm_receive_enable;
        end
        path_next.fm_to_q_mux   = ctrl_reg.voice_path_select;
        path_next.q_neg_to_bias = ctrl_reg.voice_path_select;
        path_next.bias_ref_en   = ctrl_reg.voice_path_select | ctrl_reg.iq_receive_enable;
    end

    // Pace only while the channel that samples is powered
    assign run = path_reg.q_chan_en;

    drsc_tick_gen u_tick (
        .aclk         (aclk),
        .aresetn      (aresetn),
        .run          (run),
        .mode_digital (ctrl_reg.mode_digital),
        .tick         (tick)
    );

    // --------------------------------------------------------
    // Sample capture
    // --------------------------------------------------------
    always_comb begin
        sample_next = sample_reg;
        if (tick) begin
            sample_next.q = adc_q_s2;
            sample_next.i = path_reg.i_chan_en ? adc_i_s2 : '0;
        end
    end

    // --------------------------------------------------------
    // AXI4-Lite slave
    // --------------------------------------------------------
    assign s_axi_awready = !aw_got_reg && !bvalid_reg;
    assign s_axi_wready  = !w_got_reg && !bvalid_reg;
    assign s_axi_arready = !rvalid_reg;
    assign aw_hs         = s_axi_awvalid && s_axi_awready;
    assign w_hs          = s_axi_wvalid && s_axi_wready;
    assign ar_hs         = s_axi_arvalid && s_axi_arready;

    always_comb begin
        aw_got_next = aw_got_reg;
        w_got_next  = w_got_reg;
        awaddr_next = awaddr_reg;
        wdata_next  = wdata_reg;
        wstrb_next  = wstrb_reg;
        bvalid_next = bvalid_reg;
        bresp_next  = bresp_reg;
        ctrl_next   = ctrl_reg;
        irq_en_next = irq_en_reg;
        clr_bits    = '0;
        do_write    = 1'b0;
        if (aw_hs) begin
            aw_got_next = 1'b1;
            awaddr_next = s_axi_awaddr;
        end
        if (w_hs) begin
            w_got_next = 1'b1;
            wdata_next = s_axi_wdata;
            wstrb_next = s_axi_wstrb;
        end
        if (aw_got_reg && w_got_reg) begin
            do_write    = 1'b1;
            aw_got_next = 1'b0;
            w_got_next  = 1'b0;
            bvalid_next = 1'b1;
            bresp_next  = RESP_OKAY;
            unique case ({awaddr_reg[ADDR_W-1:2], 2'b00})
                OFS_CTRL: begin
                    if (wstrb_reg[0]) begin
                        ctrl_next = drsc_ctrl_t'(wdata_reg[CTRL_W-1:0]);
                    end
                end
                OFS_IRQ_EN: begin
                    if (wstrb_reg[0]) begin
                        irq_en_next = wdata_reg[ST_W-1:0];
                    end
                end
                OFS_IRQ_CLR: begin
                    if (wstrb_reg[0]) begin
                        clr_bits = wdata_reg[ST_W-1:0];
                    end
                end
                OFS_I_SAMPLE, OFS_Q_SAMPLE, OFS_STATUS, OFS_PATH: begin
                    bresp_next = RESP_OKAY;
                end
                default: begin
                    bresp_next = RESP_SLVERR;
                end
            endcase
        end else if (bvalid_reg && s_axi_bready) begin
            bvalid_next = 1'b0;
        end
    end

    always_comb begin
        rvalid_next = rvalid_reg;
        rresp_next  = rresp_reg;
        rdata_next  = rdata_reg;
        rd_q_sample = 1'b0;
        if (ar_hs) begin
            rvalid_next = 1'b1;
            rresp_next  = RESP_OKAY;
            rdata_next  = '0;
            unique case ({s_axi_araddr[ADDR_W-1:2], 2'b00})
                OFS_CTRL:     rdata_next = {28'h000_0000, ctrl_reg};
                OFS_I_SAMPLE: rdata_next = 32'(signed'(sample_reg.i));
                OFS_Q_SAMPLE: begin
                    rdata_next  = 32'(signed'(sample_reg.q));
                    rd_q_sample = 1'b1;
                end
                OFS_STATUS:   rdata_next = {30'h0000_0000, status_reg};
                OFS_IRQ_EN:   rdata_next = {30'h0000_0000, irq_en_reg};
                OFS_IRQ_CLR:  rdata_next = '0;
                OFS_PATH:     rdata_next = {26'h000_0000, path_reg};
                default:      rresp_next = RESP_SLVERR;
            endcase
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_next = 1'b0;
        end
    end

    // --------------------------------------------------------
    // Sticky status and interrupt
    // --------------------------------------------------------
    always_comb begin
        set_bits             = '0;
        set_bits[ST_READY]   = tick;
        set_bits[ST_OVERRUN] = tick && unread_reg;
        // A new sample wins over a read or clear in the same cycle
        status_next = (status_reg & ~clr_bits) | set_bits;
        unread_next = tick ? 1'b1 : (rd_q_sample ? 1'b0 : unread_reg);
        irq_next    = |(status_next & irq_en_next);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg   <= drsc_ctrl_t'(CTRL_RST);
            sample_reg <= '0;
            path_reg   <= '0;
            status_reg <= '0;
            irq_en_reg <= '0;
            unread_reg <= 1'b0;
            irq_reg    <= 1'b0;
            aw_got_reg <= 1'b0;
            w_got_reg  <= 1'b0;
            awaddr_reg <= '0;
            wdata_reg  <= '0;
            wstrb_reg  <= '0;
            bvalid_reg <= 1'b0;
            bresp_reg  <= RESP_OKAY;
            rvalid_reg <= 1'b0;
            rresp_reg  <= RESP_OKAY;
            rdata_reg  <= '0;
        end else begin
            ctrl_reg   <= ctrl_next;
            sample_reg <= sample_next;
            path_reg   <= path_next;
            status_reg <= status_next;
            irq_en_reg <= irq_en_next;
            unread_reg <= unread_next;
            irq_reg    <= irq_next;
            aw_got_reg <= aw_got_next;
            w_got_reg  <= w_got_next;
            awaddr_reg <= awaddr_next;
            wdata_reg  <= wdata_next;
            wstrb_reg  <= wstrb_next;
            bvalid_reg <= bvalid_next;
            bresp_reg  <= bresp_next;
            rvalid_reg <= rvalid_next;
            rresp_reg  <= rresp_next;
            rdata_reg  <= rdata_next;
        end
    end

    assign s_axi_bvalid     = bvalid_reg;
    assign s_axi_bresp      = bresp_reg;
    assign s_axi_rvalid     = rvalid_reg;
    assign s_axi_rresp      = rresp_reg;
    assign s_axi_rdata      = rdata_reg;
    assign path_ctrl        = path_reg;
    assign sample_ready_irq = irq_reg;

endmodule : drsc_receive_ctrl

// ==== rtl/drsc_tick_gen.sv ====
// Sample pacing divider producing one-cycle conversion ticks
`timescale 1ns/100ps
module drsc_tick_gen (
    input  wire logic                          aclk,
    input  wire logic                          aresetn,
    input  wire logic                          run,
    input  wire logic                          mode_digital,
    output logic                               tick
);
    import drsc_pkg::*;

    logic [TICK_W-1:0] cnt_reg;
    logic [TICK_W-1:0] cnt_next;
    logic [TICK_W-1:0] period_last;
    logic              tick_next;
    logic              tick_reg;

    // --------------------------------------------------------
    // Divider
    // --------------------------------------------------------
    always_comb begin
        period_last = mode_digital ? TICK_W'(DIG_TICK_CYC - 1) : TICK_W'(ANA_TICK_CYC - 1);
        cnt_next    = cnt_reg;
        tick_next   = 1'b0;
        if (!run) begin
            cnt_next = '0;
        end else if (cnt_reg >= period_last) begin
            cnt_next  = '0;
            tick_next = 1'b1;
        end else begin
            cnt_next = cnt_reg + TICK_W'(1);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_reg  <= '0;
            tick_reg <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            tick_reg <= tick_next;
        end
    end

    assign tick = tick_reg;

endmodule : drsc_tick_gen

// ==== tb/drsc_adc_model.sv ====
// Converter model feeding results to the receive control block
`timescale 1ns/100ps
module drsc_adc_model (
    input  wire logic                          aclk,
    input  wire drsc_pkg::drsc_path_t          path_ctrl,
    input  wire logic [drsc_pkg::SAMPLE_W-1:0] i_value,
    input  wire logic [drsc_pkg::SAMPLE_W-1:0] q_value,
    output logic [drsc_pkg::SAMPLE_W-1:0]      adc_i_result,
    output logic [drsc_pkg::SAMPLE_W-1:0]      adc_q_result
);
    import drsc_pkg::*;
    logic [SAMPLE_W-1:0] churn = '0;
    always @(posedge aclk) churn <= churn + 10'h001;
    // A powered-down channel gives no stable code, so stale data cannot pass unseen
    assign adc_i_result = path_ctrl.i_chan_en ? i_value : ~churn;
    assign adc_q_result = path_ctrl.q_chan_en ? q_value : churn;
endmodule : drsc_adc_model

// ==== tb/drsc_monitor.sv ====
// Concurrent checks on the ports of the receive control block
`timescale 1ns/100ps
module drsc_monitor (
    input wire logic                aclk,
    input wire logic                aresetn,
    input wire logic                s_axi_awvalid,
    input wire logic                s_axi_awready,
    input wire logic                s_axi_wvalid,
    input wire logic                s_axi_wready,
    input wire logic [1:0]          s_axi_bresp,
    input wire logic                s_axi_bvalid,
    input wire logic                s_axi_bready,
    input wire logic                s_axi_arvalid,
    input wire logic                s_axi_arready,
    input wire logic [31:0]         s_axi_rdata,
    input wire logic [1:0]          s_axi_rresp,
    input wire logic                s_axi_rvalid,
    input wire logic                s_axi_rready,
    input wire drsc_pkg::drsc_path_t path_ctrl,
    input wire logic                sample_ready_irq
);
    import drsc_pkg::*;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ------------------------------------------------------------
    // Bus handshakes
    // ------------------------------------------------------------
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data changed while waiting");
    property p_ar_ref;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    a_ar_ref: assert property (p_ar_ref) else $error("read address taken during response");
    property p_aw_ref;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_aw_ref: assert property (p_aw_ref) else $error("write taken during response");
    property p_w_done;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
    endproperty
    a_w_done: assert property (p_w_done) else $error("write response late");
    property p_r_done;
        s_axi_arvalid && s_axi_arready |-> ##1 s_axi_rvalid;
    endproperty
    a_r_done: assert property (p_r_done) else $error("read response late");
    // ------------------------------------------------------------
    // Path decode invariants
    // ------------------------------------------------------------
    property p_i_needs_q;
        path_ctrl.i_chan_en |-> path_ctrl.q_chan_en;
    endproperty
    a_i_needs_q: assert property (p_i_needs_q) else $error("I channel on without Q");
    property p_mux_bias;
        path_ctrl.fm_to_q_mux == path_ctrl.q_neg_to_bias;
    endproperty
    a_mux_bias: assert property (p_mux_bias) else $error("mux and bias tie disagree");
    property p_i_ext;
        path_ctrl.i_chan_en |-> path_ctrl.ext_rx_en;
    endproperty
    a_i_ext: assert property (p_i_ext) else $error("digital path without external enable");
    property p_vox_bias;
        path_ctrl.fm_to_q_mux |-> path_ctrl.bias_ref_en;
    endproperty
    a_vox_bias: assert property (p_vox_bias) else $error("bias reference off in voice path");
    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_read: cover property (s_axi_rvalid && s_axi_rready);
    c_irq: cover property ($rose(sample_ready_irq));
endmodule : drsc_monitor

bind drsc_receive_ctrl drsc_monitor u_mon (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .path_ctrl(path_ctrl), .sample_ready_irq(sample_ready_irq));

// ==== tb/tb.sv ====
// Self-checking testbench for the receive control block
`timescale 1ns/100ps
module tb;
    import drsc_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [7:0] awaddr = '0, araddr = '0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = '0, rdata;
    logic [3:0] wstrb = 4'hF;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp, rs;
    logic [9:0] i_val = 10'h2A5, q_val = 10'h05A, adc_i, adc_q;
    drsc_path_t path;
    logic [31:0] d;
    int num_errors = 0, checks_done = 0, cycles = 0;
    time prev_rise = 0, last_rise = 0;
    always #5 aclk = ~aclk;
    always @(posedge irq) begin
        prev_rise = last_rise;
        last_rise = $time;
    end
    drsc_receive_ctrl dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .adc_i_result(adc_i), .adc_q_result(adc_q), .path_ctrl(path), .sample_ready_irq(irq));
    drsc_adc_model u_adc (.aclk(aclk), .path_ctrl(path), .i_value(i_val), .q_value(q_val),
        .adc_i_result(adc_i), .adc_q_result(adc_q));
    task automatic report_and_stop;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 30000) begin
            num_errors++;
            report_and_stop();
        end
    end
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: word %h expected %h", $time, got, exp);
        end
    endtask : chk_word
    task automatic chk_bit(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask : chk_bit
    // ------------------------------------------------------------
    // Bus master
    // ------------------------------------------------------------
    task automatic axi_write(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
        int n;
        logic done;
        n = 0;
        done = 1'b0;
        @(posedge aclk);
        awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        // Handshakes are judged on what stood at the edge just passed
        while (!done && n < 100) begin
            @(posedge aclk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) begin
                chk_word({30'h0, bresp}, {30'h0, er});
                bready <= 1'b0;
                done = 1'b1;
            end
        end
        if (!done) chk_bit(1'b0, 1'b1);
    endtask : axi_write
    task automatic axi_read(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
        int n;
        logic done;
        n = 0;
        done = 1'b0;
        @(posedge aclk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        while (!done && n < 100) begin
            @(posedge aclk);
            n++;
            if (arready) arvalid <= 1'b0;
            if (rvalid) begin
                v = rdata;
                r = rresp;
                rready <= 1'b0;
                done = 1'b1;
            end
        end
        if (!done) chk_bit(1'b0, 1'b1);
    endtask : axi_read
    task automatic settle;
        repeat (2) @(posedge aclk);
        #1;
    endtask : settle
    task automatic wait_irq;
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 3000) begin
            @(posedge aclk);
            n++;
        end
        chk_bit(irq, 1'b1);
    endtask : wait_irq
    function automatic logic [5:0] exp_path(input logic [3:0] c);
        logic md, vx, iq;
        md = c[0];
        vx = c[1];
        iq = c[2];
        return {md & iq, md ? iq : vx, vx, vx, md ? iq : c[3], vx | iq};
    endfunction : exp_path
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        axi_read(OFS_CTRL, d, rs);
        chk_word(d, 32'h0000_0000);
        axi_read(OFS_STATUS, d, rs);
        chk_word(d, 32'h0000_0000);
        chk_word({26'h0, path}, 32'h0000_0000);
        chk_bit(irq, 1'b0);
        $display("TEST reset done");
    endtask : t_reset
    task automatic t_path;
        for (int c = 0; c < 16; c++) begin
            axi_write(OFS_CTRL, 32'(c), RESP_OKAY);
            axi_read(OFS_PATH, d, rs);
            chk_word(d, {26'h0, exp_path(4'(c))});
            chk_word({26'h0, path}, {26'h0, exp_path(4'(c))});
        end
        $display("TEST path decode done");
    endtask : t_path
    task automatic t_sample(input logic [3:0] c, input int per, input logic i_on);
        axi_write(OFS_CTRL, {28'h0, c}, RESP_OKAY);
        axi_write(OFS_IRQ_CLR, 32'h0000_0003, RESP_OKAY);
        axi_write(OFS_IRQ_EN, 32'h0000_0001, RESP_OKAY);
        wait_irq();
        @(posedge aclk);
        i_val <= ~i_val;
        q_val <= q_val ^ 10'h201;
        axi_write(OFS_IRQ_CLR, 32'h0000_0001, RESP_OKAY);
        settle();
        chk_bit(irq, 1'b0);
        wait_irq();
        // The first rise may stem from a tick before the enable, so time the next pair
        axi_write(OFS_IRQ_CLR, 32'h0000_0001, RESP_OKAY);
        wait_irq();
        chk_word(32'(last_rise - prev_rise) / 10, 32'(per));
        axi_read(OFS_I_SAMPLE, d, rs);
        chk_word(d, i_on ? {{22{i_val[9]}}, i_val} : 32'h0000_0000);
        axi_read(OFS_Q_SAMPLE, d, rs);
        chk_word(d, {{22{q_val[9]}}, q_val});
        $display("TEST sampling mode %h done", c);
    endtask : t_sample
    task automatic t_mask_err;
        axi_write(OFS_IRQ_EN, 32'h0000_0000, RESP_OKAY);
        settle();
        chk_bit(irq, 1'b0);
        axi_read(OFS_STATUS, d, rs);
        chk_word(d, 32'h0000_0003);
        axi_write(OFS_IRQ_EN, 32'h0000_0001, RESP_OKAY);
        settle();
        chk_bit(irq, 1'b1);
        axi_write(OFS_IRQ_CLR, 32'h0000_0003, RESP_OKAY);
        settle();
        chk_bit(irq, 1'b0);
        axi_read(OFS_IRQ_CLR, d, rs);
        chk_word(d, 32'h0000_0000);
        axi_read(8'h40, d, rs);
        chk_word({rs, d[29:0]}, {RESP_SLVERR, 30'h0});
        axi_write(8'h40, 32'h0000_0001, RESP_SLVERR);
        $display("TEST mask and errors done");
    endtask : t_mask_err
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_path();
        t_sample(4'h5, DIG_TICK_CYC, 1'b1);
        t_sample(4'hA, ANA_TICK_CYC, 1'b0);
        t_mask_err();
        report_and_stop();
    end
endmodule : tb
